// File: common/adpcmt_cfg.svh
// constants for the transcoder frame pipeline
`ifndef ADPCMT_CFG_SVH
`define ADPCMT_CFG_SVH
`define ADPCMT_FRAME_BITS      8'h20
`define ADPCMT_STROBE_GAP_CYC  10'h200
`define ADPCMT_PIPE_RST        1'b0
`endif

// File: common/adpcmt_pkg.sv
// types for the transcoder frame pipeline
package adpcmt_pkg;
	typedef enum logic [1:0] {
		ADPCMT_WAIT_A,
		ADPCMT_WAIT_B
	} adpcmt_strobe_t;
	typedef enum logic {
		ADPCMT_MODE_BACKPLANE,
		ADPCMT_MODE_SYNC_SERIAL
	} adpcmt_mode_t;
endpackage

// File: verilog/adpcmt_frame_pipe.sv
// frame pipeline of the four channel transcoder: load, transcode, drive out
//
// Behaviour
// (RQ1) frame boundary from frame pulse, or from the two strobes in serial mode
// (RQ2) a whole input frame is shifted in before processing; outputs fill over a frame
// (RQ3) transcoding finishes within one frame, then the output buffers load
// (RQ4) output appears exactly two frames after its input frame, fixed
// (RQ5) auxiliary and bypass paths share the same two frame latency; this pipeline has no auxiliary or bypass path, only the transcode path
// (RQ6) strobe source spaces rising edges of each strobe by 512 clocks or more
// (RQ7) strobe source alternates the two strobes, even while moving them
// (RQ8) input latch and output swap happen together on the selected frame boundary
`timescale 1ns/100ps
`include "adpcmt_cfg.svh"
module adpcmt_frame_pipe #(
	parameter int FRAME_BITS = `ADPCMT_FRAME_BITS
) (
	// clock and reset
	input  wire logic                   clock,
	input  wire logic                   rst_n,
	// alignment
	input  wire adpcmt_pkg::adpcmt_mode_t mode,
	input  wire logic                   frame_pulse_input,
	input  wire logic                   channel_strobe_a,
	input  wire logic                   channel_strobe_b,
	// serial input stream
	input  wire logic                   ser_in,
	input  wire logic                   bit_strobe,
	// transcode hook, processed word returns one frame later
	output logic [FRAME_BITS-1:0]       xcode_in,
	input  wire logic [FRAME_BITS-1:0]  xcode_out,
	// buffered serial output
	output logic                        out_valid,
	input  wire logic                   out_ready,
	output logic                        ser_out,
	// status
	output logic                        frame_tick,
	output logic                        strobe_order_err
);
	import adpcmt_pkg::*;

	// three stage synchronisers for the frame pulse, strobe and bit strobe pins (ser_in is not synchronised), one rise pulse each
	logic fp_rise;
	logic sa_rise;
	logic sb_rise;
	logic bit_tick;

	adpcmt_pin_sync #(
		.IDLE_LEVEL(1'b0)
	) u_fp_sync (
		.clock (clock),
		.rst_n (rst_n),
		.pin   (frame_pulse_input),
		.rise  (fp_rise)
	);

	adpcmt_pin_sync #(
		.IDLE_LEVEL(1'b0)
	) u_sa_sync (
		.clock (clock),
		.rst_n (rst_n),
		.pin   (channel_strobe_a),
		.rise  (sa_rise)
	);

	adpcmt_pin_sync #(
		.IDLE_LEVEL(1'b0)
	) u_sb_sync (
		.clock (clock),
		.rst_n (rst_n),
		.pin   (channel_strobe_b),
		.rise  (sb_rise)
	);

	adpcmt_pin_sync #(
		.IDLE_LEVEL(1'b0)
	) u_bit_sync (
		.clock (clock),
		.rst_n (rst_n),
		.pin   (bit_strobe),
		.rise  (bit_tick)
	);

	// strobe order tracker: a frame begins when strobe a follows strobe b
	adpcmt_strobe_t strobe_st_ff, nxt_strobe_st;
	logic           order_err_ff, nxt_order_err;
	always_comb begin
		nxt_strobe_st = strobe_st_ff;
		nxt_order_err = order_err_ff;
		unique case (strobe_st_ff)
			ADPCMT_WAIT_A: begin
				if (sa_rise) nxt_strobe_st = ADPCMT_WAIT_B;
				else if (sb_rise) nxt_order_err = 1'b1; // [RQ7]
			end
			ADPCMT_WAIT_B: begin
				if (sb_rise) nxt_strobe_st = ADPCMT_WAIT_A;
				else if (sa_rise) nxt_order_err = 1'b1; // [RQ7]
			end
		endcase
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			strobe_st_ff <= ADPCMT_WAIT_A;
			order_err_ff <= 1'b0;
		end else begin
			strobe_st_ff <= nxt_strobe_st;
			order_err_ff <= nxt_order_err;
		end
	end
	assign strobe_order_err = order_err_ff;

	// frame boundary from the selected source
	wire sync_ser  = (mode == ADPCMT_MODE_SYNC_SERIAL);
	wire ser_frame = sa_rise & (strobe_st_ff == ADPCMT_WAIT_A);
	wire boundary  = sync_ser ? ser_frame : fp_rise; // [RQ1]
	assign frame_tick = boundary;

	// frame registers: shift in, latched frame, shift out
	logic [FRAME_BITS-1:0] in_shift_ff;
	logic [FRAME_BITS-1:0] in_frame_ff;
	logic [FRAME_BITS-1:0] out_shift_ff;

	// two entry skid buffer on the output bit stream
	logic [1:0] buf_data_ff;
	logic [1:0] buf_cnt_ff;
	wire        buf_push  = bit_tick & (buf_cnt_ff != 2'h2);
	wire        buf_pop   = out_ready & (buf_cnt_ff != 2'h0);
	wire        shift_out = buf_push;
	wire        head_bit  = out_shift_ff[FRAME_BITS-1];

	// next values of the frame registers
	wire                  shift_in      = bit_tick & ~boundary;
	wire                  shift_on      = shift_out & ~boundary;
	wire [FRAME_BITS-1:0] nxt_in_shift  = {in_shift_ff[FRAME_BITS-2:0], ser_in};
	wire [FRAME_BITS-1:0] nxt_out_shift = {out_shift_ff[FRAME_BITS-2:0], 1'b0};

	// input frame collects bits between boundaries
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			in_shift_ff <= {FRAME_BITS{`ADPCMT_PIPE_RST}};
		end else if (shift_in) begin
			in_shift_ff <= nxt_in_shift; // [RQ2]
		end
	end

	// whole input frame handed to the transcoder at the boundary
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			in_frame_ff <= {FRAME_BITS{`ADPCMT_PIPE_RST}};
		end else if (boundary) begin
			in_frame_ff <= in_shift_ff; // [RQ2] [RQ8]
		end
	end

	// result taken after one frame of transcoding: out two frames after input
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			out_shift_ff <= {FRAME_BITS{`ADPCMT_PIPE_RST}};
		end else if (boundary) begin
			out_shift_ff <= xcode_out; // [RQ3] [RQ4] [RQ5] [RQ8]
		end else if (shift_on) begin
			out_shift_ff <= nxt_out_shift; // [RQ2]
		end
	end
	assign xcode_in = in_frame_ff;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			buf_data_ff <= 2'h0;
			buf_cnt_ff  <= 2'h0;
		end else begin
			unique case ({buf_push, buf_pop})
				2'b10: begin
					buf_data_ff[buf_cnt_ff[0]] <= head_bit;
					buf_cnt_ff <= buf_cnt_ff + 2'h1;
				end
				2'b01: begin
					buf_data_ff <= {1'b0, buf_data_ff[1]};
					buf_cnt_ff <= buf_cnt_ff - 2'h1;
				end
				2'b11: begin
					if (buf_cnt_ff == 2'h1) buf_data_ff[0] <= head_bit;
					else buf_data_ff <= {head_bit, buf_data_ff[1]};
				end
				default: ;
			endcase
		end
	end
	assign out_valid = (buf_cnt_ff != 2'h0);
	assign ser_out   = buf_data_ff[0];
endmodule

// three flip-flop pin synchroniser with a one clock rise pulse
module adpcmt_pin_sync #(
	parameter logic IDLE_LEVEL = 1'b0
) (
	// clock and reset
	input  wire logic clock,
	input  wire logic rst_n,
	// pin and its qualified rise
	input  wire logic pin,
	output logic      rise
);
	logic [2:0] stage_ff;
	logic       level_ff;
	wire        agree = (stage_ff[1] == stage_ff[2]);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			stage_ff <= {3{IDLE_LEVEL}};
		end else begin
			stage_ff <= {stage_ff[1:0], pin};
		end
	end

	// level follows only once the last two stages agree
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			level_ff <= IDLE_LEVEL;
		end else if (agree) begin
			level_ff <= stage_ff[2];
		end
	end

	assign rise = agree & stage_ff[2] & ~level_ff;
endmodule

// File: verification/adpcmt_frame_pipe_chk.sv
// port assertions for the frame pipeline
`timescale 1ns/100ps
module adpcmt_frame_pipe_chk #(parameter int FRAME_BITS=32)(
	// clock, reset, alignment
	input wire logic clock,rst_n,frame_pulse_input,channel_strobe_a,
	input wire adpcmt_pkg::adpcmt_mode_t mode,
	// outputs, and the out_ready input
	input wire logic [FRAME_BITS-1:0] xcode_in,
	input wire logic out_valid,out_ready,ser_out,frame_tick,strobe_order_err);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	a_pulse_tick:assert property(!mode&&$rose(frame_pulse_input)|->##[1:5]frame_tick)else $error("no tick");
	a_strobe_tick:assert property(mode&&$rose(channel_strobe_a)|->##[1:5]frame_tick)else $error("no tick");
	a_tick_once:assert property(frame_tick|=>!frame_tick)else $error("long tick");
	a_xcode_hold:assert property(!frame_tick&&!$past(frame_tick)|=>$stable(xcode_in))else $error("moved");
	a_err_sticky:assert property(strobe_order_err|=>strobe_order_err)else $error("err lost");
	a_err_mode:assert property($rose(strobe_order_err)|->mode)else $error("err in backplane");
	a_out_hold:assert property(out_valid&&!out_ready|=>out_valid&&$stable(ser_out))else $error("lost");
endmodule
bind adpcmt_frame_pipe adpcmt_frame_pipe_chk #(.FRAME_BITS(FRAME_BITS)) chk(.clock,.rst_n,.frame_pulse_input,
	.channel_strobe_a,.mode,.xcode_in,.out_valid,.out_ready,.ser_out,.frame_tick,.strobe_order_err);

// File: verification/adpcmt_line_model.sv
// line side: alignment strobes and one word per 520 clock frame
`timescale 1ns/100ps
module adpcmt_line_model(
	input wire logic clock,mode,skip_a,
	output logic frame_pulse_input=0,channel_strobe_a=0,channel_strobe_b=0,ser_in=0,bit_strobe=0,
	output int frm=0);
	int c=0;
	wire [31:0] w={4{frm[7:0]}}^32'h5A3C96E1;
	always @(negedge clock) begin
		c<=c==519?0:c+1;
		if(c==519)frm<=frm+1;
		frame_pulse_input<=!mode&&c<2;
		channel_strobe_a<=mode&&!skip_a&&c<2;
		channel_strobe_b<=mode&&c>259&&c<262;
		bit_strobe<=c>7&&(c-8)%16<2;
		// released between bits: toggles every clock, starting from the inverse of the last bit
		if(c>7&&(c-8)%16<8)ser_in<=w[31-(c-8)/16];else ser_in<=!ser_in;
	end
endmodule

// File: verification/tb_adpcmt_frame_pipe.sv
// testbench for the frame pipeline
`timescale 1ns/100ps
module tb_adpcmt_frame_pipe;
	import adpcmt_pkg::*;
	logic clock=0,rst_n=0,out_ready=0,skip_a=0;
	adpcmt_mode_t mode=ADPCMT_MODE_BACKPLANE;
	logic [31:0] xcode_in,xcode_out=0,rx=0;
	logic frame_pulse_input,channel_strobe_a,channel_strobe_b,ser_in,bit_strobe,out_valid,ser_out,frame_tick,err;
	int frm,errors=0,check_count=0,cyc=0;
	always #20 clock=~clock;
	adpcmt_line_model pm(.clock,.mode,.skip_a,.frame_pulse_input,.channel_strobe_a,.channel_strobe_b,.ser_in,
		.bit_strobe,.frm);
	adpcmt_frame_pipe #(.FRAME_BITS(32)) uut(.clock,.rst_n,.mode,.frame_pulse_input,.channel_strobe_a,
		.channel_strobe_b,.ser_in,.bit_strobe,.xcode_in,.xcode_out,.out_valid,.out_ready,.ser_out,.frame_tick,
		.strobe_order_err(err));
	always @(negedge clock) begin
		cyc<=cyc+1;
		out_ready<=cyc[4:2]!=0;// stall 4 of every 32 cycles
		xcode_out<=~xcode_in;// stand-in transcoder
	end
	always @(posedge clock) if(out_valid&&out_ready)rx<={rx[30:0],ser_out};
	function logic [31:0] word(int f);
		return {4{f[7:0]}}^32'h5A3C96E1;
	endfunction
	task chk(logic [31:0] seen,exp);
		check_count++;
		if(seen!==exp) begin
			errors++;
			$display("mismatch at %0t: seen %h expected %h",$time,seen,exp);
		end
	endtask
	task frames(int n);
		repeat(n) begin
			@(frm);
			#1;
			if(frm>3) begin
				chk(xcode_in,word(frm-2));
				chk(rx,~word(frm-3));
			end
		end
	endtask
	task t_backplane;
		frames(6);
		$display("backplane latency done");
	endtask
	task t_serial;
		mode=ADPCMT_MODE_SYNC_SERIAL;
		frames(5);
		chk(err,0);
		$display("strobe latency done");
	endtask
	task t_skip;
		skip_a=1;
		@(frm);
		skip_a=0;
		@(frm);
		#1;
		chk(err,1);
		$display("strobe repeat done");
	endtask
	task close_out;
		$display("errors %0d checks %0d",errors,check_count);
		if(errors==0&&check_count>0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat(8)@(posedge clock);
		@(negedge clock) rst_n=1;
		t_backplane;
		t_serial;
		t_skip;
		close_out;
	end
	initial begin
		#400000;
		errors++;
		close_out;
	end
endmodule
